// ==== hdl/ucfc_core.sv ====
/*
 * ucfc_core: baud generator, clock modes and frame transmitter/receiver of a serial unit.
 * assumes APB master on sys_clk; pins are synchronous to sys_clk except the slave clock,
 * which is synchronised here.
 */
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ucfc_core
   import ucfc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   input wire logic xfer_clock_pin_i,
   output logic xfer_clock_pin_o,
   output logic xfer_clock_pin_oe
);
   logic [31:0] ctrl_q, ctrl_d;
   logic [11:0] baud_q, baud_d;
   logic [11:0] cnt_q, cnt_d;
   logic tick;
   ucfc_cfg_s cfg;
   logic wrEn, rdEn, lowWrite, txWrite, rxRead;
   logic master, slave;
   logic xs1_q, xs2_q, xs3_q;
   logic xcoBit_q, xcoBit_d;
   logic changeEdge, sampleEdge, txStep;
   logic [3:0] txPre_q, txPre_d;
   logic [3:0] divM1;
   logic [8:0] txBuf_q, txBuf_d;
   logic txFull_q, txFull_d;
   ucfc_tx_e txSt_q, txSt_d;
   logic [8:0] txSh_q, txSh_d;
   logic [3:0] txCnt_q, txCnt_d;
   logic txPar_q, txPar_d;
   logic txOut_q, txOut_d;
   logic [3:0] nBits;
   ucfc_rx_e rxSt_q, rxSt_d;
   logic [3:0] rxPh_q, rxPh_d;
   logic [3:0] rxCnt_q, rxCnt_d;
   logic [8:0] rxSh_q, rxSh_d;
   logic rxPar_q, rxPar_d;
   logic rxSample, rxBit;
   ucfc_rxword_s rxFifo_q [RX_DEPTH];
   ucfc_rxword_s rxFifo_d [RX_DEPTH];
   logic [1:0] rxLvl_q, rxLvl_d;
   logic ovr_q, ovr_d;
   logic push;
   ucfc_rxword_s pushWord;
   logic [31:0] rdata_d;

   assign cfg = '{sync: ctrl_q[CTRL_SYNC], dbl: ctrl_q[CTRL_DBL], xDir: ctrl_q[CTRL_XDIR],
                  pol: ctrl_q[CTRL_POL], csz: ctrl_q[CTRL_CSZ+:3], par: ctrl_q[CTRL_PAR+:2],
                  twoStop: ctrl_q[CTRL_STOP]};
   assign master = cfg.sync & cfg.xDir;
   assign slave = cfg.sync & ~cfg.xDir;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & penable & ~pwrite;
   assign lowWrite = wrEn & (paddr == ADDR_BAUD);
   assign txWrite = wrEn & (paddr == ADDR_TXDATA);
   assign rxRead = rdEn & (paddr == ADDR_RXDATA);

   // registers and read mux
   always_comb begin
      ctrl_d = ctrl_q;
      baud_d = baud_q;
      if (wrEn && paddr == ADDR_CTRL) begin
         ctrl_d = {19'h0, pwdata[12:0]};
      end
      if (lowWrite) begin
         baud_d = pwdata[11:0];
      end
      rdata_d = 32'h0;
      case (paddr)
         ADDR_CTRL: rdata_d = ctrl_q;
         ADDR_BAUD: rdata_d = {20'h0, baud_q};
         ADDR_RXDATA: rdata_d = {21'h0, rxFifo_q[0].parityErr, rxFifo_q[0].frameErr,
                                 rxFifo_q[0].data};
         ADDR_STATUS: rdata_d = {28'h0, ovr_q, rxLvl_q != 2'h0, ~txFull_q,
                                 txSt_q == TX_IDLE};
         default: rdata_d = 32'h0;
      endcase
   end

   // baud down-counter
   always_comb begin
      tick = (cnt_q == 12'h000);
      if (lowWrite || tick) begin
         cnt_d = lowWrite ? pwdata[11:0] : baud_q;
      end else begin
         cnt_d = cnt_q - 12'h001;
      end
   end

   // master clock and slave edges: xs1 feeds only xs2
   always_comb begin
      xcoBit_d = xcoBit_q;
      if (!master) begin
         xcoBit_d = cfg.pol;
      end else if (tick) begin
         xcoBit_d = ~xcoBit_q;
      end
      changeEdge = 1'b0;
      sampleEdge = 1'b0;
      if (master && tick) begin
         // polarity 0: change on rising, sample on falling
         changeEdge = (xcoBit_q == cfg.pol);
         sampleEdge = (xcoBit_q != cfg.pol);
      end else if (slave) begin
         changeEdge = (xs2_q != xs3_q) && (xs2_q != cfg.pol);
         sampleEdge = (xs2_q != xs3_q) && (xs2_q == cfg.pol);
      end
   end
   assign xfer_clock_pin_o = xcoBit_q;
   assign xfer_clock_pin_oe = master;

   // transmitter prescaler
   always_comb begin
      divM1 = cfg.dbl ? 4'(DIV_DOUBLE - 5'h01) : 4'(DIV_NORMAL - 5'h01);
      txPre_d = txPre_q;
      txStep = 1'b0;
      if (cfg.sync) begin
         txStep = changeEdge;
      end else if (tick) begin
         if (txPre_q >= divM1) begin
            txPre_d = 4'h0;
            txStep = 1'b1;
         end else begin
            txPre_d = txPre_q + 4'h1;
         end
      end
      nBits = (cfg.csz == CSZ_NINE) ? 4'h9 : {1'b0, cfg.csz} + 4'h5;
   end

   // transmitter
   always_comb begin
      txBuf_d = txBuf_q;
      txFull_d = txFull_q;
      txSt_d = txSt_q;
      txSh_d = txSh_q;
      txCnt_d = txCnt_q;
      txPar_d = txPar_q;
      txOut_d = txOut_q;
      if (txStep) begin
         case (txSt_q)
            TX_IDLE: begin
               txOut_d = 1'b1;
               if (txFull_q && ctrl_q[CTRL_TXEN]) begin
                  txSh_d = txBuf_q;
                  txFull_d = 1'b0;
                  txPar_d = cfg.par[0];
                  txOut_d = 1'b0;
                  txSt_d = TX_START;
               end
            end
            TX_START, TX_DATA: begin
               txOut_d = txSh_q[0];
               txPar_d = txPar_q ^ txSh_q[0];
               txSh_d = {1'b0, txSh_q[8:1]};
               txCnt_d = txCnt_q + 4'h1;
               txSt_d = TX_DATA;
               if (txCnt_q == nBits) begin
                  txCnt_d = 4'h0;
                  txOut_d = cfg.par[1] ? txPar_q : 1'b1;
                  txPar_d = txPar_q;
                  txSh_d = txSh_q;
                  txSt_d = cfg.par[1] ? TX_PARITY : TX_STOP;
               end
            end
            TX_PARITY: begin
               txOut_d = 1'b1;
               txSt_d = TX_STOP;
            end
            TX_STOP: begin
               txOut_d = 1'b1;
               txSt_d = TX_STOP;
               if (cfg.twoStop && txCnt_q == 4'h0 && txOut_q) begin
                  txCnt_d = 4'h1;
               end else if (txFull_q && ctrl_q[CTRL_TXEN]) begin
                  // back-to-back: next start right after last stop
                  txSh_d = txBuf_q;
                  txFull_d = 1'b0;
                  txPar_d = cfg.par[0];
                  txOut_d = 1'b0;
                  txCnt_d = 4'h0;
                  txSt_d = TX_START;
               end else begin
                  txCnt_d = 4'h0;
                  txSt_d = TX_IDLE;
               end
            end
            default: txSt_d = TX_IDLE;
         endcase
      end
      if (txWrite && !txFull_d) begin
         txBuf_d = {ctrl_q[CTRL_NINTH], pwdata[7:0]};
         txFull_d = 1'b1;
      end
   end
   assign serial_out_pin = txOut_q;

   // receiver: phase counts undivided ticks in async, holds in sync where sampleEdge samples
   always_comb begin
      rxBit = serial_in_pin;
      rxPh_d = rxPh_q;
      rxSample = 1'b0;
      if (cfg.sync) begin
         rxSample = sampleEdge;
      end else if (tick) begin
         rxPh_d = rxPh_q + 4'h1;
         if (rxSt_q == RX_START) begin
            rxSample = (rxPh_q == {1'b0, divM1[3:1]}); // mid start bit
         end else begin
            rxSample = (rxPh_q == divM1);
         end
         if (rxSample) begin
            rxPh_d = 4'h0;
         end
      end
      rxSt_d = rxSt_q;
      rxCnt_d = rxCnt_q;
      rxSh_d = rxSh_q;
      rxPar_d = rxPar_q;
      push = 1'b0;
      pushWord = '{data: rxSh_q, frameErr: 1'b0, parityErr: 1'b0};
      case (rxSt_q)
         RX_IDLE: begin
            rxPh_d = 4'h0;
            if (ctrl_q[CTRL_RXEN] && (cfg.sync ? (rxSample && !rxBit) : !rxBit)) begin
               rxSt_d = cfg.sync ? RX_DATA : RX_START;
               rxCnt_d = 4'h0;
               rxPar_d = cfg.par[0];
               rxSh_d = 9'h000;
            end
         end
         RX_START: if (rxSample) begin
            rxSt_d = rxBit ? RX_IDLE : RX_DATA; // false start rejected
         end
         RX_DATA: if (rxSample) begin
            rxSh_d = rxSh_q | (9'(rxBit) << rxCnt_q);
            rxPar_d = rxPar_q ^ rxBit;
            rxCnt_d = rxCnt_q + 4'h1;
            if (rxCnt_q + 4'h1 == nBits) begin
               rxSt_d = cfg.par[1] ? RX_PARITY : RX_STOP;
            end
         end
         RX_PARITY: if (rxSample) begin
            rxPar_d = rxPar_q ^ rxBit;
            rxSt_d = RX_STOP;
         end
         RX_STOP: if (rxSample) begin
            // second stop bit never examined
            push = 1'b1;
            pushWord = '{data: rxSh_q, frameErr: ~rxBit,
                         parityErr: cfg.par[1] & rxPar_q};
            rxSt_d = RX_IDLE;
         end
         default: rxSt_d = RX_IDLE;
      endcase
   end

   // two-entry receive buffer, overrun sticky until buffer read
   always_comb begin
      rxFifo_d = rxFifo_q;
      rxLvl_d = rxLvl_q;
      ovr_d = ovr_q;
      if (rxRead && rxLvl_q != 2'h0) begin
         rxFifo_d[0] = rxFifo_q[1];
         rxLvl_d = rxLvl_q - 2'h1;
         ovr_d = 1'b0;
      end
      if (push) begin
         if (rxLvl_d == 2'(RX_DEPTH)) begin
            ovr_d = 1'b1;
         end else begin
            rxFifo_d[rxLvl_d[0]] = pushWord;
            rxLvl_d = rxLvl_d + 2'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
         baud_q <= BAUD_RESET;
         cnt_q <= BAUD_RESET;
         xs1_q <= 1'b0;
         xs2_q <= 1'b0;
         xs3_q <= 1'b0;
         xcoBit_q <= 1'b0;
         txPre_q <= 4'h0;
         txBuf_q <= 9'h000;
         txFull_q <= 1'b0;
         txSt_q <= TX_IDLE;
         txSh_q <= 9'h000;
         txCnt_q <= 4'h0;
         txPar_q <= 1'b0;
         txOut_q <= 1'b1;
         rxSt_q <= RX_IDLE;
         rxPh_q <= 4'h0;
         rxCnt_q <= 4'h0;
         rxSh_q <= 9'h000;
         rxPar_q <= 1'b0;
         rxFifo_q <= '{default: '0};
         rxLvl_q <= 2'h0;
         ovr_q <= 1'b0;
         prdata <= 32'h0;
      end else begin
         ctrl_q <= ctrl_d;
         baud_q <= baud_d;
         cnt_q <= cnt_d;
         xs1_q <= xfer_clock_pin_i;
         xs2_q <= xs1_q;
         xs3_q <= xs2_q;
         xcoBit_q <= xcoBit_d;
         txPre_q <= txPre_d;
         txBuf_q <= txBuf_d;
         txFull_q <= txFull_d;
         txSt_q <= txSt_d;
         txSh_q <= txSh_d;
         txCnt_q <= txCnt_d;
         txPar_q <= txPar_d;
         txOut_q <= txOut_d;
         rxSt_q <= rxSt_d;
         rxPh_q <= rxPh_d;
         rxCnt_q <= rxCnt_d;
         rxSh_q <= rxSh_d;
         rxPar_q <= rxPar_d;
         rxFifo_q <= rxFifo_d;
         rxLvl_q <= rxLvl_d;
         ovr_q <= ovr_d;
         prdata <= rdata_d;
      end
   end

   a_tick_reload: assert property (@(posedge sys_clk) disable iff (rst)
      tick && !lowWrite |=> cnt_q == baud_q) else $error("counter not reloaded");
   a_low_reload: assert property (@(posedge sys_clk) disable iff (rst)
      lowWrite |=> cnt_q == $past(pwdata[11:0])) else $error("low write no reload");
   a_count_down: assert property (@(posedge sys_clk) disable iff (rst)
      !tick && !lowWrite |=> cnt_q == $past(cnt_q) - 12'h001) else $error("no count");
   a_pin_dir: assert property (@(posedge sys_clk) disable iff (rst)
      !cfg.sync |-> !xfer_clock_pin_oe) else $error("clock pin driven async");
   a_start_low: assert property (@(posedge sys_clk) disable iff (rst)
      txSt_q == TX_START |-> !serial_out_pin) else $error("start not low");
   a_stop_high: assert property (@(posedge sys_clk) disable iff (rst)
      txSt_q == TX_STOP || txSt_q == TX_IDLE |-> serial_out_pin) else $error("stop low");
   a_rx_level: assert property (@(posedge sys_clk) disable iff (rst)
      rxLvl_q <= 2'(RX_DEPTH)) else $error("receive buffer level too high");
   a_overrun_set: assert property (@(posedge sys_clk) disable iff (rst)
      push && rxLvl_q == 2'h2 && !rxRead |=> ovr_q) else $error("overrun missed");
   a_slave_edge: assert property (@(posedge sys_clk) disable iff (rst)
      slave && sampleEdge |-> $past(xfer_clock_pin_i, 3) != $past(xfer_clock_pin_i, 2))
      else $error("edge not from pin");
   c_frame_sent: cover property (@(posedge sys_clk) txSt_q == TX_STOP ##1 txSt_q == TX_START);
   c_frame_rcvd: cover property (@(posedge sys_clk) push && !pushWord.frameErr);
   c_frame_err: cover property (@(posedge sys_clk) push && pushWord.frameErr);
   c_master_clk: cover property (@(posedge sys_clk) master && changeEdge);
endmodule // ucfc_core
`default_nettype wire

// ==== hdl/ucfc_pkg.sv ====
/*
 * ucfc_pkg: constants, register map and types for the serial clock and frame core.
 * assumes an APB slave with 32-bit data and one aligned word per register.
 */
package ucfc_pkg;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_BAUD = 12'h004;
   localparam logic [11:0] ADDR_TXDATA = 12'h008;
   localparam logic [11:0] ADDR_RXDATA = 12'h00C;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   // ctrl field positions
   localparam int CTRL_SYNC = 0;
   localparam int CTRL_DBL = 1;
   localparam int CTRL_XDIR = 2;
   localparam int CTRL_POL = 3;
   localparam int CTRL_CSZ = 4;
   localparam int CTRL_PAR = 7;
   localparam int CTRL_STOP = 9;
   localparam int CTRL_NINTH = 10;
   localparam int CTRL_TXEN = 11;
   localparam int CTRL_RXEN = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0030;
   localparam logic [11:0] BAUD_RESET = 12'h000;
   localparam logic [2:0] CSZ_NINE = 3'h7;
   localparam logic [4:0] DIV_NORMAL = 5'h10;
   localparam logic [4:0] DIV_DOUBLE = 5'h08;
   localparam logic [4:0] DIV_SYNC = 5'h02;
   localparam int RX_DEPTH = 2;

   typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ucfc_tx_e;
   typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ucfc_rx_e;

   typedef struct packed {
      logic [8:0] data;
      logic frameErr;
      logic parityErr;
   } ucfc_rxword_s;

   typedef struct packed {
      logic sync;
      logic dbl;
      logic xDir;
      logic pol;
      logic [2:0] csz;
      logic [1:0] par;
      logic twoStop;
   } ucfc_cfg_s;
endpackage

// ==== verif/testbench.sv ====
/*
 * testbench: APB tasks and serial scenarios for ucfc_core.
 * assumes ucfc_remote as far-end device and a 200 MHz sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import ucfc_pkg::*;
   localparam int DIV = 2;
   localparam int TK = DIV + 1;
   logic sysClk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdData;
   logic rdErr;
   logic pready, pslverr, txLine, xclkOut, xclkOe, remOut, rxPin, xclkWire;
   logic tbRx = 1'h1, tbClk = 1'h0, useTb = 1'h0;
   int fail_count = 0, cmp_count = 0;
   logic [2:0] cszT [5] = '{3'h0, 3'h1, 3'h2, 3'h3, CSZ_NINE};
   logic [1:0] parT [5] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h3};
   logic stopT [5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
   logic [8:0] datT [5] = '{9'h015, 9'h02C, 9'h06B, 9'h0E1, 9'h1A5};

   always #2.5 sysClk = ~sysClk;
   assign rxPin = useTb ? tbRx : remOut;
   // wire level of the clock pin from both drivers
   assign xclkWire = xclkOe ? xclkOut : tbClk;

   ucfc_core ucfc_core_inst (.sys_clk(sysClk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_in_pin(rxPin), .serial_out_pin(txLine),
      .xfer_clock_pin_i(xclkWire), .xfer_clock_pin_o(xclkOut), .xfer_clock_pin_oe(xclkOe));
   ucfc_remote ucfc_remote_inst (.sys_clk(sysClk), .lineIn(txLine), .lineOut(remOut));

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one idle cycle after each transfer keeps psel from being driven twice at one edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sysClk);
      penable <= 1'h1;
      @(posedge sysClk);
      while (pready !== 1'h1) @(posedge sysClk);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge sysClk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      apb(1'h0, a, 32'h0);
      check(rdData, exp, what);
      check(rdErr, 32'h0, "slave error");
   endtask

   // polls status until the transmit buffer has room again
   task automatic wait_tx_room();
      int k;
      k = 0;
      apb(1'h0, ADDR_STATUS, 32'h0);
      while (rdData[1] !== 1'h1 && k < 100) begin
         apb(1'h0, ADDR_STATUS, 32'h0);
         k++;
      end
   endtask

   // empties the receive buffer of words that no check expects
   task automatic drain_rx();
      for (int k = 0; k < 3; k++) begin
         apb(1'h0, ADDR_RXDATA, 32'h0);
      end
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] csz, input logic [1:0] par,
                                       input logic two, input logic [3:0] mode, input logic nin);
      ctl = 32'h0;
      ctl[3:0] = mode;
      ctl[CTRL_CSZ +: 3] = csz;
      ctl[CTRL_PAR +: 2] = par;
      ctl[CTRL_STOP] = two;
      ctl[CTRL_NINTH] = nin;
      ctl[CTRL_TXEN] = 1'h1;
      ctl[CTRL_RXEN] = 1'h1;
   endfunction

   function automatic int mkframe(input logic [8:0] d, input logic [2:0] csz,
                                  input logic [1:0] par, input logic two, output logic [12:0] f);
      int nb;
      int n;
      nb = (csz == CSZ_NINE) ? 9 : int'(csz) + 5;
      f = '1;
      f[0] = 1'h0;
      for (int i = 0; i < nb; i++) f[1 + i] = d[i];
      n = nb + 1;
      if (par[1]) begin
         f[n] = ^(d & ((9'h1 << nb) - 9'h1)) ^ par[0];
         n++;
      end
      return n + 1 + int'(two); // stops left high
   endfunction

   task automatic round(input logic [31:0] c, input logic [8:0] d, input int bitCyc);
      logic [12:0] f, g;
      int n, gap;
      n = mkframe(d, c[CTRL_CSZ +: 3], c[CTRL_PAR +: 2], c[CTRL_STOP], f);
      wr(ADDR_CTRL, c);
      wr(ADDR_TXDATA, {24'h0, d[7:0]});
      ucfc_remote_inst.recv(n, bitCyc, g, gap);
      check(g, f, "tx frame");
      ucfc_remote_inst.send(f, n, bitCyc);
      rd(ADDR_RXDATA, {23'h0, d}, "rx word");
   endtask

   task automatic sync_recv(input logic pol, input int n, output logic [12:0] f);
      int k;
      int gap;
      logic prev;
      k = 0;
      gap = 0;
      f = '1;
      prev = xclkOut;
      while (k < n && gap < 4000) begin
         @(posedge sysClk);
         gap++;
         if (prev !== pol && xclkOut === pol && (k > 0 || txLine === 1'h0)) begin
            if (k > 0) check(gap, 2 * TK, "clock period");
            f[k] = txLine;
            k++;
            gap = 0;
         end
         prev = xclkOut;
      end
   endtask

   // clock stands still outside the frame; data moves on the rising edge
   task automatic slave_send(input logic [12:0] f, input int n);
      useTb <= 1'h1;
      for (int i = 0; i < n; i++) begin
         tbClk <= 1'h1;
         tbRx <= f[i];
         repeat (5) @(posedge sysClk);
         tbClk <= 1'h0; // ten-cycle period, under a quarter rate
         repeat (5) @(posedge sysClk);
      end
   endtask

   initial begin
      repeat (40000) @(posedge sysClk);
      fail_count++;
      close_out();
   end

   initial begin
      logic [12:0] f, g;
      int n, gap;
      repeat (6) @(posedge sysClk);
      rst <= 1'h0;
      @(posedge sysClk);
      check(txLine, 32'h1, "idle line");
      check(xclkOe, 32'h0, "clock pin off");
      rd(ADDR_CTRL, CTRL_RESET, "ctrl reset");
      rd(ADDR_STATUS, 32'h3, "status reset");
      rd(12'h014, 32'h0, "unmapped");
      wr(ADDR_BAUD, 32'h0000_FFFF);
      rd(ADDR_BAUD, 32'h0000_0FFF, "divisor width");
      wr(ADDR_BAUD, DIV);
      for (int i = 0; i < 5; i++) begin
         round(ctl(cszT[i], parT[i], stopT[i], 4'h0, datT[i][8]), datT[i], 16 * TK);
      end
      round(ctl(3'h3, 2'h2, 1'h0, 4'h2, 1'h0), 9'h0C3, 8 * TK);
      wr(ADDR_CTRL, ctl(3'h3, 2'h0, 1'h0, 4'h0, 1'h0));
      wr(ADDR_TXDATA, 32'h55);
      wait_tx_room(); // a full buffer refuses the second word
      check(rdData[1], 32'h1, "buffer freed");
      wr(ADDR_TXDATA, 32'hAA);
      n = mkframe(9'h055, 3'h3, 2'h0, 1'h0, f);
      ucfc_remote_inst.recv(n, 16 * TK, g, gap);
      check(g, f, "first frame");
      n = mkframe(9'h0AA, 3'h3, 2'h0, 1'h0, f);
      ucfc_remote_inst.recv(n, 16 * TK, g, gap);
      check(g, f, "second frame");
      check(gap <= 8 * TK + 3, 32'h1, "frame gap");
      for (int i = 0; i < 3; i++) begin
         n = mkframe({7'h28, 2'(i)}, 3'h3, 2'h0, 1'h0, f);
         ucfc_remote_inst.send(f, n, 16 * TK);
      end
      rd(ADDR_STATUS, 32'hF, "overrun");
      rd(ADDR_RXDATA, 32'h0A0, "oldest word");
      rd(ADDR_RXDATA, 32'h0A1, "second word");
      rd(ADDR_STATUS, 32'h3, "drained");
      // eight bits, even parity, two stops; break parity, first stop, second stop
      wr(ADDR_CTRL, ctl(3'h3, 2'h2, 1'h1, 4'h0, 1'h0));
      n = mkframe(9'h033, 3'h3, 2'h2, 1'h1, f);
      for (int i = 9; i < 12; i++) begin
         g = f;
         g[i] = ~g[i];
         ucfc_remote_inst.send(g, n, 16 * TK);
         rd(ADDR_RXDATA, {21'h0, i == 9, i == 10, 9'h033}, "error flags");
         // a low stop bit reads as a start: let that frame end, then empty the buffer
         repeat (12 * 16 * TK) @(posedge sysClk);
         drain_rx();
      end
      rd(ADDR_STATUS, 32'h3, "emptied");
      for (int p = 0; p < 2; p++) begin
         wr(ADDR_CTRL, ctl(3'h3, 2'h0, 1'h0, {p[0], 3'h5}, 1'h0));
         repeat (2) @(posedge sysClk);
         check(xclkOe, 32'h1, "master drives clock");
         wr(ADDR_TXDATA, 32'h96);
         n = mkframe(9'h096, 3'h3, 2'h0, 1'h0, f);
         sync_recv(p[0], n, g);
         check(g, f, "sync frame");
      end
      wr(ADDR_CTRL, ctl(3'h3, 2'h0, 1'h0, 4'h1, 1'h0)); // double speed kept low
      repeat (2) @(posedge sysClk);
      check(xclkOe, 32'h0, "slave takes clock");
      n = mkframe(9'h05A, 3'h3, 2'h0, 1'h0, f);
      slave_send(f, n);
      rd(ADDR_RXDATA, 32'h05A, "slave word");
      close_out();
   end
endmodule // testbench
`default_nettype wire

// ==== verif/ucfc_remote.sv ====
/*
 * ucfc_remote: far-end asynchronous serial device for the core's bench.
 * assumes the core's sys_clk; the bench calls send and recv by hierarchy.
 */
`timescale 1ns/100ps
`default_nettype none
module ucfc_remote (
   input wire logic sys_clk,
   input wire logic lineIn,
   output logic lineOut
);
   initial lineOut = 1'h1; // idle high

   // bits lsb first: start low, data lsb first, parity, stops high
   task automatic send(input logic [12:0] bits, input int n, input int bitCyc);
      for (int i = 0; i < n; i++) begin
         lineOut <= bits[i];
         repeat (bitCyc) @(posedge sys_clk);
      end
      lineOut <= 1'h1; // back to idle
      @(posedge sys_clk); // keeps a following call off this time step
   endtask

   // gap counts idle cycles before the start edge; samples at mid-bit
   task automatic recv(input int n, input int bitCyc, output logic [12:0] bits,
                       output int gap);
      gap = 0;
      bits = '1;
      while (lineIn !== 1'h0 && gap < 4000) begin
         @(posedge sys_clk);
         gap++;
      end
      repeat (bitCyc / 2) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         bits[i] = lineIn;
         if (i < n - 1) repeat (bitCyc) @(posedge sys_clk);
      end
   endtask
endmodule // ucfc_remote
`default_nettype wire
